/* File: design/cpw_config_port.sv */
// configuration port decoder, index/data registers and wake output
// What this block does
// - only ring or clock falling edges wake
// - wake output is active-low open-drain
// - global enable clear blocks wake output
// - enabled source can assert wake output
// - per-source wake status is recorded, readable
// - event flag sets regardless of global enable
// - power-on and hard resets leave run state, devices disabled
// - index/data ports ignored in run state, except the entry key at the index port
// - strap picks base 0x03f0 or 0x0370
// - base relocatable via two base registers
// - every decode qualified by inactive aen
// - key 0x55 enters configuration state
// - key 0xaa returns to run state
// - index at base, data at base+1
// - global registers ignore device selection
// - two states; run always accepts entry key
// - control bit 0 triggers soft reset
module cpw_config_port
    import cpw_pkg::*;
#(
    parameter int          NUM_LD = 9,
    parameter logic [7:0]  DEV_ID = 8'h5a // arbitrary value
) (
    input  wire logic              clock_i,
    input  wire logic              srst_i,
    input  wire logic              host_hard_reset_i,
    input  wire logic              base_select_strap_i,
    input  wire logic              aen_i,
    input  wire logic              iow_n_i,
    input  wire logic              ior_n_i,
    input  wire logic [CPW_AW-1:0] addr_i,
    input  wire logic [CPW_DW-1:0] data_i,
    input  wire logic              ring_indicate_a_n_i,
    input  wire logic              ring_indicate_b_n_i,
    input  wire logic              kbd_clk_i,
    input  wire logic              mouse_clk_i,
    output logic      [CPW_DW-1:0] data_o,
    output logic                   data_oe_o,
    output logic                   wake_event_out_n_o,
    output logic                   wake_event_out_oe_o,
    output logic      [NUM_LD-1:0] ld_active_o,
    output logic                   cfg_state_o,
    output logic      [CPW_AW-1:0] cfg_base_o
);
    // key state and registers
    cpw_state_t         state_reg;
    cpw_state_t         state_next;

    logic [7:0]         index_reg;
    logic [7:0]         ldn_reg;
    logic [7:0]         cfg_base_low_reg;
    logic [7:0]         cfg_base_high_reg;
    logic [NUM_LD-1:0]  activate_reg;
    logic               soft_rst_reg;

    // wake enables, read path
    logic               wake_global_enable_reg;
    logic [CPW_NSRC-1:0] wake_src_en_reg;
    logic [CPW_DW-1:0]  data_out_reg;
    logic               data_oe_reg;

    // synchronised pin events
    logic               hard_lvl;
    logic               hard_fall;

    logic               iow_fall;
    logic               ior_fall;
    logic               ior_rise;
    logic               any_rst;

    // wake sources and results
    logic [CPW_NSRC-1:0] src_lvl;
    logic [CPW_NSRC-1:0] src_fall;
    logic [CPW_NSRC-1:0] src_pins;
    logic [CPW_NSRC-1:0] wake_status;
    logic               wake_event_flag;
    logic               wake_pull;

    // decode terms
    logic [CPW_AW-1:0]  base_addr;
    logic               hit_index;
    logic               hit_data;
    logic               in_cfg;
    logic               wr_cfg_port;
    logic               wr_data;
    logic               rd_port;
    logic               wake_ld;
    logic               sts_clr;
    logic               flg_clr;

    // true when the bus address selects base plus offset
    // aen high marks a dma cycle
    function automatic logic port_hit(input logic [CPW_AW-1:0] a,
                                      input logic [CPW_AW-1:0] b,
                                      input logic [CPW_AW-1:0] ofs,
                                      input logic              en_n);
        port_hit = !en_n && (a == b + ofs);
    endfunction

    // hard reset pin is asynchronous, so it is synchronised like the strobes
    cpw_pin_sync #(.IDLE(1'b0)) u_sync_hard (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .pin_i   (host_hard_reset_i),
        .level_o (hard_lvl),
        .fall_o  (hard_fall),
        .rise_o  ()
    );

    // write strobe
    cpw_pin_sync #(.IDLE(1'b1)) u_sync_iow (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .pin_i   (iow_n_i),
        .level_o (),
        .fall_o  (iow_fall),
        .rise_o  ()
    );

    // read strobe; its rise frees the bus
    cpw_pin_sync #(.IDLE(1'b1)) u_sync_ior (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .pin_i   (ior_n_i),
        .level_o (),
        .fall_o  (ior_fall),
        .rise_o  (ior_rise)
    );

    // wake sources: ring indicators and the two serial clocks
    assign src_pins = {
        mouse_clk_i,         // status bit 3
        kbd_clk_i,           // status bit 2
        ring_indicate_b_n_i, // status bit 1
        ring_indicate_a_n_i  // status bit 0
    };

    // one synchroniser per source
    for (genvar g = 0; g < CPW_NSRC; g++) begin : g_src
        cpw_pin_sync #(.IDLE(1'b1)) u_sync_src (
            .clock_i (clock_i),
            .srst_i  (srst_i),
            .pin_i   (src_pins[g]),
            .level_o (src_lvl[g]),
            .fall_o  (src_fall[g]),
            .rise_o  ()
        );
    end

    // a hard reset holds the block like the power-on reset, but the base registers reload only as it ends
    // strobe syncs keep running through it
    assign any_rst   = srst_i | hard_lvl;

    // address decode, always gated by aen
    assign base_addr = {cfg_base_high_reg, cfg_base_low_reg};
    assign hit_index = port_hit(addr_i, base_addr, '0, aen_i);
    assign hit_data  = port_hit(addr_i, base_addr, CPW_DATA_OFS, aen_i);
    assign in_cfg    = (state_reg == CPW_CFG);

    // address and data are assumed stable for the whole strobe
    // a strobe under two clocks may be missed
    assign wr_cfg_port = iow_fall & hit_index;
    assign wr_data     = iow_fall & hit_data & in_cfg;
    assign rd_port     = ior_fall & (hit_index | hit_data) & in_cfg;

    // wake device write strobes
    assign wake_ld     = (ldn_reg == CPW_LDN_WAKE);
    assign sts_clr     = wr_data & wake_ld & (index_reg == CPW_IDX_WAKE_STS);
    assign flg_clr     = wr_data & wake_ld & (index_reg == CPW_IDX_WAKE_FLG);

    // two-state key machine
    // keys only count at the config port
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            CPW_RUN: begin
                if (wr_cfg_port && data_i == CPW_KEY_ENTER) begin
                    state_next = CPW_CFG;
                end
                // any other value leaves the state alone
            end
            CPW_CFG: begin
                if (wr_cfg_port && data_i == CPW_KEY_EXIT) begin
                    state_next = CPW_RUN;
                end
            end
            default: begin
                state_next = CPW_RUN;
            end
        endcase
    end

    // state register; run after a power-on or hard reset
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            state_reg <= CPW_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // index register; the exit key is not taken as an index
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            index_reg <= CPW_ZERO_BYTE;
        end else if (wr_cfg_port && in_cfg && data_i != CPW_KEY_EXIT) begin
            index_reg <= data_i;
        end
    end

    // logical device number, cleared by soft reset too
    always_ff @(posedge clock_i) begin
        if (any_rst || soft_rst_reg) begin
            ldn_reg <= CPW_LDN_RST;
        end else if (wr_data && index_reg == CPW_IDX_LDN) begin
            ldn_reg <= data_i;
        end
    end

    // soft reset is a one-cycle pulse from control bit 0
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= wr_data && index_reg == CPW_IDX_CTRL && data_i[CPW_CTRL_SOFT];
        end
    end

    // base registers: strap is read directly in reset cycles, where a
    // brief metastable sample is harmless as the pin is a static strap
    // a soft reset leaves the base alone
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cfg_base_low_reg  <= base_select_strap_i ? CPW_BASE_LO_S1 : CPW_BASE_LO_S0;
            cfg_base_high_reg <= CPW_BASE_HI_DEF;
        end else if (hard_fall) begin
            cfg_base_low_reg  <= base_select_strap_i ? CPW_BASE_LO_S1 : CPW_BASE_LO_S0;
            cfg_base_high_reg <= CPW_BASE_HI_DEF;
        end else if (wr_data && index_reg == CPW_IDX_BASE_LO) begin
            cfg_base_low_reg  <= data_i;
        end else if (wr_data && index_reg == CPW_IDX_BASE_HI) begin
            cfg_base_high_reg <= data_i;
        end
    end

    // activate bits of each logical device; all off after any reset
    // numbers past the last device are ignored
    always_ff @(posedge clock_i) begin
        if (any_rst || soft_rst_reg) begin
            activate_reg <= '0;
        end else if (wr_data && index_reg == CPW_IDX_ACTIVATE && ldn_reg < 8'(NUM_LD)) begin
            activate_reg[ldn_reg[3:0]] <= data_i[CPW_ACT_BIT];
        end
    end

    // wake enables live in the wake logical device
    // writes to other devices leave them alone
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            wake_global_enable_reg <= 1'b0;
            wake_src_en_reg        <= '0;
        end else if (wr_data && wake_ld) begin
            if (index_reg == CPW_IDX_WAKE_GEN) begin
                wake_global_enable_reg <= data_i[CPW_GEN_BIT];
            end
            if (index_reg == CPW_IDX_WAKE_ENA) begin
                wake_src_en_reg <= data_i[CPW_NSRC-1:0];
            end
        end
    end

    // status, flag and pin pull request
    cpw_wake_events #(.NSRC(CPW_NSRC)) u_wake (
        .clock_i     (clock_i),
        .srst_i      (any_rst),
        .src_fall_i  (src_fall),
        .global_en_i (wake_global_enable_reg),
        .src_en_i    (wake_src_en_reg),
        .sts_clr_i   (sts_clr),
        .flg_clr_i   (flg_clr),
        .clr_mask_i  (data_i[CPW_NSRC-1:0]),
        .status_o    (wake_status),
        .flag_o      (wake_event_flag),
        .pull_o      (wake_pull)
    );

    // read mux of the data port
    // write-only and unknown indices read zero
    function automatic logic [7:0] cfg_read(input logic [7:0] idx,
                                            input logic       wld);
        cfg_read = CPW_ZERO_BYTE;
        unique case (idx)
            CPW_IDX_LDN:      cfg_read = ldn_reg;
            CPW_IDX_DEV_ID:   cfg_read = DEV_ID;
            CPW_IDX_BASE_LO:  cfg_read = cfg_base_low_reg;
            CPW_IDX_BASE_HI:  cfg_read = cfg_base_high_reg;
            CPW_IDX_ACTIVATE: cfg_read = (ldn_reg < 8'(NUM_LD)) ?
                                         {7'h00, activate_reg[ldn_reg[3:0]]} : CPW_ZERO_BYTE;
            CPW_IDX_WAKE_GEN: cfg_read = wld ? {7'h00, wake_global_enable_reg} : CPW_ZERO_BYTE;
            CPW_IDX_WAKE_FLG: cfg_read = wld ? {7'h00, wake_event_flag} : CPW_ZERO_BYTE;
            CPW_IDX_WAKE_STS: cfg_read = wld ? {4'h0, wake_status} : CPW_ZERO_BYTE;
            CPW_IDX_WAKE_ENA: cfg_read = wld ? {4'h0, wake_src_en_reg} : CPW_ZERO_BYTE;
            default:          cfg_read = CPW_ZERO_BYTE;
        endcase
    endfunction

    // read data is latched at strobe start and held until it ends
    // the index port reads back the index itself
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            data_out_reg <= CPW_ZERO_BYTE;
        end else if (rd_port) begin
            data_out_reg <= hit_index ? index_reg : cfg_read(index_reg, wake_ld);
        end
    end

    // bus driver enable; the host turns it off by ending the strobe
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            data_oe_reg <= 1'b0;
        end else if (rd_port) begin
            data_oe_reg <= 1'b1;
        end else if (ior_rise) begin
            data_oe_reg <= 1'b0;
        end
    end

    // bus outputs straight from registers
    assign data_o              = data_out_reg;
    assign data_oe_o           = data_oe_reg;

    // open drain: level fixed low, only the enable moves
    assign wake_event_out_n_o  = 1'b0;
    assign wake_event_out_oe_o = wake_pull;

    assign ld_active_o         = activate_reg;
    assign cfg_state_o         = state_reg[1];
    assign cfg_base_o          = base_addr;
endmodule

/* File: design/cpw_pkg.sv */
// constants for the configuration port and wake event block
package cpw_pkg;
    localparam int          CPW_AW           = 16;
    localparam int          CPW_DW           = 8;
    // configuration port base chosen by the strap
    localparam logic [7:0]  CPW_BASE_HI_DEF  = 8'h03;
    localparam logic [7:0]  CPW_BASE_LO_S0   = 8'hf0;
    localparam logic [7:0]  CPW_BASE_LO_S1   = 8'h70;
    localparam logic [15:0] CPW_DATA_OFS     = 16'h0001;
    // keys written to the configuration port
    localparam logic [7:0]  CPW_KEY_ENTER    = 8'h55;
    localparam logic [7:0]  CPW_KEY_EXIT     = 8'haa;
    // global register indices
    localparam logic [7:0]  CPW_IDX_CTRL     = 8'h02;
    localparam logic [7:0]  CPW_IDX_LDN      = 8'h07;
    localparam logic [7:0]  CPW_IDX_DEV_ID   = 8'h20;
    localparam logic [7:0]  CPW_IDX_BASE_LO  = 8'h26;
    localparam logic [7:0]  CPW_IDX_BASE_HI  = 8'h27;
    // per logical device indices
    localparam logic [7:0]  CPW_IDX_ACTIVATE = 8'h30;
    localparam logic [7:0]  CPW_IDX_WAKE_GEN = 8'hc5;
    localparam logic [7:0]  CPW_IDX_WAKE_FLG = 8'hc6;
    localparam logic [7:0]  CPW_IDX_WAKE_STS = 8'hc7;
    localparam logic [7:0]  CPW_IDX_WAKE_ENA = 8'hc8;
    localparam logic [7:0]  CPW_LDN_WAKE     = 8'h08;
    // field positions and reset values
    localparam int          CPW_CTRL_SOFT    = 0;
    localparam int          CPW_ACT_BIT      = 0;
    localparam int          CPW_GEN_BIT      = 0;
    localparam int          CPW_FLG_BIT      = 0;
    localparam int          CPW_NSRC         = 4;
    localparam logic [7:0]  CPW_LDN_RST      = 8'h00;
    localparam logic [7:0]  CPW_ZERO_BYTE    = 8'h00;

    typedef enum logic [1:0] {
        CPW_RUN = 2'b01,
        CPW_CFG = 2'b10
    } cpw_state_t;
endpackage

/* File: design/cpw_pin_sync.sv */
// three-stage pin synchroniser with agreed level and edge pulses
module cpw_pin_sync #(
    parameter logic IDLE = 1'b1
) (
    input  wire logic clock_i,
    input  wire logic srst_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      fall_o,
    output logic      rise_o
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;

    // first stage feeds only the second one
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            s1_reg    <= IDLE;
            s2_reg    <= IDLE;
            s3_reg    <= IDLE;
            level_reg <= IDLE;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_reg <= s3_reg;
            end
        end
    end

    // a change counts once stages two and three agree
    assign level_o = level_reg;
    assign fall_o  = level_reg & ~s2_reg & ~s3_reg;
    assign rise_o  = ~level_reg & s2_reg & s3_reg;
endmodule

/* File: design/cpw_wake_events.sv */
// wake source status, event flag and open-drain pull request
module cpw_wake_events
    import cpw_pkg::*;
#(
    parameter int NSRC = CPW_NSRC
) (
    input  wire logic            clock_i,
    input  wire logic            srst_i,
    input  wire logic [NSRC-1:0] src_fall_i,
    input  wire logic            global_en_i,
    input  wire logic [NSRC-1:0] src_en_i,
    input  wire logic            sts_clr_i,
    input  wire logic            flg_clr_i,
    input  wire logic [NSRC-1:0] clr_mask_i,
    output logic      [NSRC-1:0] status_o,
    output logic                 flag_o,
    output logic                 pull_o
);
    logic [NSRC-1:0] status_reg;
    logic            flag_reg;
    logic            pull_reg;
    logic [NSRC-1:0] clr_bits;

    assign clr_bits = sts_clr_i ? clr_mask_i : '0;

    // write one clears a source bit; a new edge in that cycle wins
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~clr_bits) | (src_fall_i & src_en_i);
        end
    end

    // event flag ignores the global enable; set beats clear
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            flag_reg <= 1'b0;
        end else if (|src_fall_i) begin
            flag_reg <= 1'b1;
        end else if (flg_clr_i && clr_mask_i[CPW_FLG_BIT]) begin
            flag_reg <= 1'b0;
        end
    end

    // only enabled sources pull, and only under the global enable
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pull_reg <= 1'b0;
        end else begin
            pull_reg <= global_en_i & |(status_reg & src_en_i);
        end
    end

    assign status_o = status_reg;
    assign flag_o   = flag_reg;
    assign pull_o   = pull_reg;
endmodule

/* File: bench/cpw_config_port_asserts.sv */
// checker for the configuration port decoder and wake output
module cpw_cp_chk
    import cpw_pkg::*;
(
    input wire logic              clock_i,
    input wire logic              srst_i,
    input wire logic              host_hard_reset_i,
    input wire logic              base_select_strap_i,
    input wire logic              aen_i,
    input wire logic              iow_n_i,
    input wire logic [CPW_AW-1:0] addr_i,
    input wire logic [CPW_DW-1:0] data_i,
    input wire logic              ring_indicate_a_n_i,
    input wire logic              ring_indicate_b_n_i,
    input wire logic              kbd_clk_i,
    input wire logic              mouse_clk_i,
    input wire logic              data_oe_o,
    input wire logic              wake_event_out_n_o,
    input wire logic              wake_event_out_oe_o,
    input wire logic [8:0]        ld_active_o,
    input wire logic              cfg_state_o,
    input wire logic [CPW_AW-1:0] cfg_base_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] src_q;
    logic [3:0] fall_age;
    logic [3:0] hr_age;
    wire logic [3:0] src = {mouse_clk_i, kbd_clk_i, ring_indicate_b_n_i, ring_indicate_a_n_i};
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);
    // cycles since any source pin fell; the pins are async so this is only a bound
    always_ff @(posedge clock_i) begin
        src_q <= src;
        if (srst_i || |(src_q & ~src)) fall_age <= 4'h0;
        else if (fall_age != 4'hf) fall_age <= fall_age + 4'h1;
    end
    // cycles since the hard reset pin was last high, so its slow reload is excused
    always_ff @(posedge clock_i) begin
        if (srst_i || host_hard_reset_i) hr_age <= 4'h0;
        else if (hr_age != 4'hf) hr_age <= hr_age + 4'h1;
    end
    wake_pin_low_a: assert property (wake_event_out_n_o == 1'b0)
        else $error("wake pin level not low");
    wake_cause_a: assert property ($rose(wake_event_out_oe_o) |-> fall_age <= 4'h6)
        else $error("wake asserted without a source edge");
    reset_state_a: assert property (disable iff (1'b0) srst_i |=> !cfg_state_o && ld_active_o == 9'h000)
        else $error("reset left state or devices set");
    strap_base_a: assert property (disable iff (1'b0) srst_i |=>
        cfg_base_o == {CPW_BASE_HI_DEF, base_select_strap_i ? CPW_BASE_LO_S1 : CPW_BASE_LO_S0})
        else $error("base does not follow strap");
    read_gate_a: assert property ($rose(data_oe_o) |-> cfg_state_o && !aen_i &&
        addr_i[15:1] == cfg_base_o[15:1]) else $error("read answered outside decode");
    enter_key_a: assert property ($rose(cfg_state_o) |-> !iow_n_i && !aen_i &&
        data_i == CPW_KEY_ENTER && addr_i == cfg_base_o) else $error("entered without key");
    exit_key_a: assert property ($fell(cfg_state_o) && hr_age > 4'h8 |->
        !iow_n_i && data_i == CPW_KEY_EXIT && addr_i == cfg_base_o) else $error("left without key");
    base_move_a: assert property (!$stable(cfg_base_o) && hr_age > 4'h8 |->
        $past(cfg_state_o) && !$past(iow_n_i)) else $error("base moved without a write");
    cover property ($rose(wake_event_out_oe_o));
    cover property ($rose(cfg_state_o));
    cover property ($fell(ld_active_o[8]));
endmodule

bind cpw_config_port cpw_cp_chk u_chk (.clock_i(clock_i), .srst_i(srst_i),
    .host_hard_reset_i(host_hard_reset_i), .base_select_strap_i(base_select_strap_i), .aen_i(aen_i),
    .iow_n_i(iow_n_i), .addr_i(addr_i), .data_i(data_i), .ring_indicate_a_n_i(ring_indicate_a_n_i),
    .ring_indicate_b_n_i(ring_indicate_b_n_i), .kbd_clk_i(kbd_clk_i), .mouse_clk_i(mouse_clk_i),
    .data_oe_o(data_oe_o), .wake_event_out_n_o(wake_event_out_n_o),
    .wake_event_out_oe_o(wake_event_out_oe_o), .ld_active_o(ld_active_o),
    .cfg_state_o(cfg_state_o), .cfg_base_o(cfg_base_o));

/* File: bench/cpw_host_model.sv */
// host bus model: strobed byte writes and reads
module cpw_host_model
    import cpw_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic [CPW_DW-1:0] rd_data_i,
    input  wire logic              rd_oe_i,
    output logic                   aen_o,
    output logic                   iow_n_o,
    output logic                   ior_n_o,
    output logic      [CPW_AW-1:0] addr_o,
    output logic      [CPW_DW-1:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        aen_o = 1'b0;
        iow_n_o = 1'b1;
        ior_n_o = 1'b1;
        addr_o = 16'h0000;
        wdata_o = 8'h00;
    end
    // six cycles each side, above the four the pin synchroniser needs
    task automatic io_write(input logic [15:0] a, input logic [7:0] d, input logic blk);
        @(posedge clock_i);
        aen_o <= blk;
        addr_o <= a;
        wdata_o <= d;
        iow_n_o <= 1'b0;
        repeat (6) @(posedge clock_i);
        iow_n_o <= 1'b1;
        repeat (6) @(posedge clock_i);
        aen_o <= 1'b0;
        addr_o <= ~a; // released bus shows the inverse, never a stale copy
        wdata_o <= ~d;
    endtask
    task automatic io_read(input logic [15:0] a, output logic [7:0] d, output logic oe);
        @(posedge clock_i);
        addr_o <= a;
        ior_n_o <= 1'b0;
        repeat (6) @(posedge clock_i);
        d = rd_data_i;
        oe = rd_oe_i;
        ior_n_o <= 1'b1;
        repeat (6) @(posedge clock_i);
        addr_o <= ~a;
    endtask
endmodule

/* File: bench/cpw_config_port_test.sv */
// self-checking bench for the configuration port and wake block
module cpw_config_port_test
    import cpw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] DEV = 8'h5a; // arbitrary value
    logic clock_i = 1'b0, srst_i = 1'b1, hard = 1'b0, strap = 1'b0;
    logic aen, iow_n, ior_n, data_oe, wk_n, wk_oe, cfg_state;
    logic [15:0] addr, cfg_base;
    logic [15:0] base = 16'h03f0;
    logic [7:0] wdata, data_o;
    logic [3:0] src = 4'hf;
    logic [8:0] ld_active;
    int failures = 0, tests_run = 0;
    always #50 clock_i = ~clock_i;
    cpw_host_model u_host (.clock_i(clock_i), .rd_data_i(data_o), .rd_oe_i(data_oe), .aen_o(aen),
        .iow_n_o(iow_n), .ior_n_o(ior_n), .addr_o(addr), .wdata_o(wdata));
    cpw_config_port #(.DEV_ID(DEV)) u_dut (.clock_i(clock_i), .srst_i(srst_i), .host_hard_reset_i(hard),
        .base_select_strap_i(strap), .aen_i(aen), .iow_n_i(iow_n), .ior_n_i(ior_n), .addr_i(addr),
        .data_i(wdata), .ring_indicate_a_n_i(src[0]), .ring_indicate_b_n_i(src[1]), .kbd_clk_i(src[2]),
        .mouse_clk_i(src[3]), .data_o(data_o), .data_oe_o(data_oe), .wake_event_out_n_o(wk_n),
        .wake_event_out_oe_o(wk_oe), .ld_active_o(ld_active), .cfg_state_o(cfg_state),
        .cfg_base_o(cfg_base));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        u_host.io_write(a, d, 1'b0);
    endtask
    task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
        wr(base, i);
        wr(base + 16'h1, d);
    endtask
    // reads through the data port; the enable bit is folded in so a silent port fails
    task automatic reg_chk(input logic [7:0] i, input logic [7:0] exp);
        logic [7:0] d;
        logic oe;
        wr(base, i);
        u_host.io_read(base + 16'h1, d, oe);
        check({7'h00, oe, d}, {8'h01, exp});
    endtask
    // one source pin low then high again, long enough for the synchroniser
    task automatic pulse_src(input int k);
        @(posedge clock_i);
        src[k] <= 1'b0;
        repeat (8) @(posedge clock_i);
        src[k] <= 1'b1;
        repeat (8) @(posedge clock_i);
    endtask
    task automatic t_reset();
        check({6'h00, cfg_state, ld_active}, 16'h0000);
        check(cfg_base, 16'h03f0);
        $display("reset test done");
    endtask
    task automatic t_run_ignore();
        logic [7:0] d;
        logic oe;
        wr(base, CPW_KEY_EXIT);
        wr(base, 8'h12);
        wr(base + 16'h1, CPW_KEY_ENTER);
        check({15'h0000, cfg_state}, 16'h0000);
        u_host.io_read(base + 16'h1, d, oe);
        check({15'h0000, oe}, 16'h0000);
        u_host.io_write(base, CPW_KEY_ENTER, 1'b1);
        check({15'h0000, cfg_state}, 16'h0000);
        wr(base, CPW_KEY_ENTER);
        check({15'h0000, cfg_state}, 16'h0001);
        $display("run state test done");
    endtask
    task automatic t_regs();
        logic [7:0] d;
        logic oe;
        reg_wr(CPW_IDX_LDN, CPW_LDN_WAKE);
        reg_chk(CPW_IDX_LDN, CPW_LDN_WAKE);
        u_host.io_read(base, d, oe);
        check({7'h00, oe, d}, {8'h01, CPW_IDX_LDN});
        reg_chk(CPW_IDX_DEV_ID, DEV);
        reg_wr(CPW_IDX_ACTIVATE, 8'h01);
        check({7'h00, ld_active}, 16'h0100);
        $display("register test done");
    endtask
    task automatic t_wake();
        reg_wr(CPW_IDX_WAKE_ENA, 8'h01);
        reg_wr(CPW_IDX_WAKE_GEN, 8'h00);
        pulse_src(0);
        check({14'h0000, wk_n, wk_oe}, 16'h0000);
        reg_chk(CPW_IDX_WAKE_FLG, 8'h01);
        reg_chk(CPW_IDX_WAKE_STS, 8'h01);
        reg_wr(CPW_IDX_WAKE_STS, 8'h01);
        reg_wr(CPW_IDX_WAKE_FLG, 8'h01);
        reg_chk(CPW_IDX_WAKE_STS, 8'h00);
        reg_chk(CPW_IDX_WAKE_ENA, 8'h01);
        reg_wr(CPW_IDX_WAKE_GEN, 8'h01);
        pulse_src(2);
        check({15'h0000, wk_oe}, 16'h0000);
        reg_chk(CPW_IDX_WAKE_FLG, 8'h01);
        pulse_src(0);
        check({14'h0000, wk_n, wk_oe}, 16'h0001);
        reg_chk(CPW_IDX_WAKE_STS, 8'h01);
        reg_wr(CPW_IDX_WAKE_STS, 8'h01);
        check({15'h0000, wk_oe}, 16'h0000);
        $display("wake test done");
    endtask
    task automatic t_soft_base();
        logic [7:0] d;
        logic oe;
        reg_wr(CPW_IDX_CTRL, 8'h01);
        check({7'h00, ld_active}, 16'h0000);
        reg_chk(CPW_IDX_LDN, CPW_LDN_RST);
        reg_wr(CPW_IDX_BASE_LO, 8'h10);
        base = 16'h0310;
        check(cfg_base, base);
        u_host.io_read(base, d, oe);
        check({7'h00, oe, d}, {8'h01, CPW_IDX_BASE_LO});
        wr(base, CPW_KEY_EXIT);
        check({15'h0000, cfg_state}, 16'h0000);
        $display("soft reset and base test done");
    endtask
    // hard reset mid configuration, strap now high
    task automatic t_hard();
        wr(base, CPW_KEY_ENTER);
        strap <= 1'b1;
        hard <= 1'b1;
        repeat (6) @(posedge clock_i);
        hard <= 1'b0;
        repeat (8) @(posedge clock_i);
        check(cfg_base, 16'h0370);
        check({6'h00, cfg_state, ld_active}, 16'h0000);
        $display("hard reset test done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        t_reset();
        t_run_ignore();
        t_regs();
        t_wake();
        t_soft_base();
        t_hard();
        tally_and_finish();
    end
    // the run needs roughly 700 cycles; seven times that means a hang
    initial begin
        #500000;
        failures++;
        tally_and_finish();
    end
endmodule
